// file: include/ars_pkg.sv
// Shared constants and types for the rotate/subtract/xor/swap datapath slice.
// Assumes a single 10 MHz bus clock and word-only AHB-Lite accesses.
package ars_pkg;

    // ============================================================
    // Widths and sizes
    localparam int ARS_DATA_W = 8;
    localparam int ARS_FADDR_W = 7;
    localparam int ARS_FILE_DEPTH = 128;
    localparam int ARS_CMD_W = 24;
    localparam int ARS_CNT_W = 16;

    // ============================================================
    // Register byte offsets (low address byte only)
    localparam logic [7:0] ARS_OFS_CMD = 8'h00;
    localparam logic [7:0] ARS_OFS_ACC = 8'h04;
    localparam logic [7:0] ARS_OFS_FLAGS = 8'h08;
    localparam logic [7:0] ARS_OFS_WIN = 8'h0C;
    localparam logic [7:0] ARS_OFS_FDATA = 8'h10;
    localparam logic [7:0] ARS_OFS_COUNT = 8'h14;

    // ============================================================
    // Command word fields
    localparam int ARS_CMD_OP_LSB = 0;
    localparam int ARS_CMD_DEST_BIT = 3;
    localparam int ARS_CMD_FA_LSB = 4;
    localparam int ARS_CMD_IMM_LSB = 16;

    // Flag word bit positions
    localparam int ARS_FLAG_CARRY = 0;
    localparam int ARS_FLAG_NB = 1;
    localparam int ARS_FLAG_ZERO = 2;

    // ============================================================
    // Reset values
    localparam logic [7:0] ARS_ACC_RST = 8'h00;
    localparam logic [23:0] ARS_CMD_RST = 24'h000000;
    localparam logic [6:0] ARS_WIN_RST = 7'h00;
    localparam logic [15:0] ARS_CNT_RST = 16'h0000;
    localparam logic [31:0] ARS_RDATA_RST = 32'h00000000;

    // ============================================================
    // Operation codes; 0 and 7 execute nothing
    typedef enum logic [2:0] {
        ARS_OP_NONE = 3'h0,
        ARS_OP_ROT = 3'h1,
        ARS_OP_SUBL = 3'h2,
        ARS_OP_SUBF = 3'h3,
        ARS_OP_XORL = 3'h4,
        ARS_OP_XORF = 3'h5,
        ARS_OP_SWAP = 3'h6,
        ARS_OP_RSVD = 3'h7
    } ars_op_t;

    // Bus slave states, one-hot
    typedef enum logic [3:0] {
        ARS_ST_IDLE = 4'h1,
        ARS_ST_WRITE = 4'h2,
        ARS_ST_RWAIT = 4'h4,
        ARS_ST_RDONE = 4'h8
    } ars_bus_st_t;

    // ============================================================
    // Minuend minus subtrahend: {carry, nibble_borrow_bit, result}
    function automatic logic [9:0] ars_sub_fn(input logic [7:0] minu, input logic [7:0] subt);
        logic [7:0] diff;
        diff = 8'(minu - subt);
        return {(subt <= minu), (subt[3:0] <= minu[3:0]), diff};
    endfunction

endpackage

// file: core/ars_alu.sv
// Combinational operation unit for the six single-operand instructions.
// Assumes the caller picks the destination and applies the flag updates.
`timescale 1ns/10ps

module ars_alu
    import ars_pkg::*;
(
    // Operation and operands
    input wire logic [2:0] op,
    input wire logic [7:0] acc,
    input wire logic [7:0] fval,
    input wire logic [7:0] imm,
    input wire logic carry_in,
    // Results
    output logic [7:0] result,
    output logic carry_out,
    output logic nb_out,
    output logic upd_carry,
    output logic upd_nb,
    output logic upd_zero,
    output logic file_op,
    output logic valid_op
);

    logic [9:0] sub_l;
    logic [9:0] sub_f;

    always_comb begin
        sub_l = ars_sub_fn(imm, acc);
        sub_f = ars_sub_fn(fval, acc);
        result = fval;
        carry_out = carry_in;
        nb_out = 1'b0;
        upd_carry = 1'b0;
        upd_nb = 1'b0;
        upd_zero = 1'b0;
        file_op = 1'b0;
        valid_op = 1'b1;
        unique case (op)
            ARS_OP_ROT: begin
                result = {carry_in, fval[7:1]};
                carry_out = fval[0];
                upd_carry = 1'b1;
                file_op = 1'b1;
            end
            ARS_OP_SUBL: begin
                result = sub_l[7:0];
                carry_out = sub_l[9];
                nb_out = sub_l[8];
                upd_carry = 1'b1;
                upd_nb = 1'b1;
                upd_zero = 1'b1;
            end
            ARS_OP_SUBF: begin
                result = sub_f[7:0];
                carry_out = sub_f[9];
                nb_out = sub_f[8];
                upd_carry = 1'b1;
                upd_nb = 1'b1;
                upd_zero = 1'b1;
                file_op = 1'b1;
            end
            ARS_OP_XORL: begin
                result = acc ^ imm;
                upd_zero = 1'b1;
            end
            ARS_OP_XORF: begin
                result = acc ^ fval;
                upd_zero = 1'b1;
                file_op = 1'b1;
            end
            ARS_OP_SWAP: begin
                result = {fval[3:0], fval[7:4]};
                file_op = 1'b1;
            end
            ARS_OP_NONE, ARS_OP_RSVD: begin
                valid_op = 1'b0;
            end
        endcase
    end

endmodule

// file: core/ars_regfile.sv
// File register array: one write port, two asynchronous read ports.
// Assumes contents need no reset; software initialises what it uses.
`timescale 1ns/10ps

module ars_regfile #(
    parameter int DEPTH = 128,
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock
    input wire logic hclk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read ports
    input wire logic [AW-1:0] raddr_a,
    output logic [DW-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [DW-1:0] rdata_b
);

    logic [DW-1:0] mem [DEPTH];

    // Asynchronous read lets an instruction read and write back in one cycle
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

endmodule

// file: core/ars_top.sv
// Rotate/subtract/xor/swap datapath slice with accumulator, flags and file registers.
// Assumes one AHB-Lite master, word-only single transfers, hready tied to hreadyout.
//
// How it works
// - Rotate right: file operand shifts right, old carry in at top, bit 0 to carry.
// - File-register instructions write accumulator when dest is 0, file register when 1.
// - Rotate with dest set replaces the addressed file register, address 0 to 127.
// - Immediate minus accumulator into accumulator; carry when acc <= immediate; zero updated.
// - Subtract-immediate nibble borrow set when acc low nibble <= immediate low nibble.
// - File minus accumulator; carry and nibble borrow from comparisons; zero updated.
// - Xor immediate into accumulator; only zero changes.
// - Xor accumulator with file operand to selected destination; only zero changes.
// - Nibble exchange swaps operand halves to destination; no flag changes.
`timescale 1ns/10ps

module ars_top
    import ars_pkg::*;
#(
    parameter int FILE_DEPTH = ARS_FILE_DEPTH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // ============================================================
    // State
    ars_bus_st_t state_ff, nxt_state;
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] acc_ff, nxt_acc;
    logic carry_ff, nxt_carry;
    logic nb_ff, nxt_nb;
    logic zero_ff, nxt_zero;
    logic [23:0] cmd_ff, nxt_cmd;
    logic [6:0] win_ff, nxt_win;
    logic [15:0] count_ff, nxt_count;
    logic [31:0] hrdata_ff, nxt_hrdata;

    logic take;
    logic wr_phase;
    logic exec;
    logic [23:0] cmd_cur;
    logic [2:0] op_cur;
    logic dest_cur;
    logic [6:0] fa_cur;
    logic [7:0] imm_cur;
    logic [7:0] fval;
    logic [7:0] win_data;
    logic [7:0] alu_result;
    logic alu_carry;
    logic alu_nb;
    logic upd_carry;
    logic upd_nb;
    logic upd_zero;
    logic file_op;
    logic valid_op;
    logic to_file;
    logic f_we;
    logic [6:0] f_waddr;
    logic [7:0] f_wdata;

    // ============================================================
    // Command decode; a command being written executes with its own fields
    assign take = hsel && hready && htrans[1];
    assign wr_phase = (state_ff == ARS_ST_WRITE);
    assign exec = wr_phase && (addr_ff == ARS_OFS_CMD);
    assign cmd_cur = exec ? hwdata[23:0] : cmd_ff;
    assign op_cur = cmd_cur[ARS_CMD_OP_LSB +: 3];
    assign dest_cur = cmd_cur[ARS_CMD_DEST_BIT];
    assign fa_cur = cmd_cur[ARS_CMD_FA_LSB +: 7];
    assign imm_cur = cmd_cur[ARS_CMD_IMM_LSB +: 8];
    assign to_file = file_op && dest_cur;

    ars_alu u_alu (
        .op(op_cur),
        .acc(acc_ff),
        .fval(fval),
        .imm(imm_cur),
        .carry_in(carry_ff),
        .result(alu_result),
        .carry_out(alu_carry),
        .nb_out(alu_nb),
        .upd_carry(upd_carry),
        .upd_nb(upd_nb),
        .upd_zero(upd_zero),
        .file_op(file_op),
        .valid_op(valid_op)
    );

    ars_regfile #(
        .DEPTH(FILE_DEPTH),
        .AW(ARS_FADDR_W),
        .DW(ARS_DATA_W)
    ) u_file (
        .hclk(hclk),
        .we(f_we),
        .waddr(f_waddr),
        .wdata(f_wdata),
        .raddr_a(fa_cur),
        .rdata_a(fval),
        .raddr_b(win_ff),
        .rdata_b(win_data)
    );

    // ============================================================
    // Next-state logic
    always_comb begin
        nxt_state = ARS_ST_IDLE;
        nxt_addr = addr_ff;
        nxt_acc = acc_ff;
        nxt_carry = carry_ff;
        nxt_nb = nb_ff;
        nxt_zero = zero_ff;
        nxt_cmd = cmd_ff;
        nxt_win = win_ff;
        nxt_count = count_ff;
        nxt_hrdata = hrdata_ff;
        f_we = 1'b0;
        f_waddr = win_ff;
        f_wdata = hwdata[7:0];

        // Write data phase: all effects land on the closing edge
        if (wr_phase) begin
            unique case (addr_ff)
                ARS_OFS_CMD: begin
                    nxt_cmd = hwdata[23:0];
                    // Literal operations never raise file_op, so their destination
                    // bit is ignored and the result always lands in the accumulator.
                    if (valid_op) begin
                        nxt_count = 16'(count_ff + 16'h0001);
                        if (to_file) begin
                            f_we = 1'b1;
                            f_waddr = fa_cur;
                            f_wdata = alu_result;
                        end else begin
                            nxt_acc = alu_result;
                        end
                        if (upd_carry) begin
                            nxt_carry = alu_carry;
                        end
                        if (upd_nb) begin
                            nxt_nb = alu_nb;
                        end
                        if (upd_zero) begin
                            nxt_zero = (alu_result == 8'h00);
                        end
                    end
                end
                ARS_OFS_ACC: nxt_acc = hwdata[7:0];
                ARS_OFS_FLAGS: begin
                    nxt_carry = hwdata[ARS_FLAG_CARRY];
                    nxt_nb = hwdata[ARS_FLAG_NB];
                    nxt_zero = hwdata[ARS_FLAG_ZERO];
                end
                ARS_OFS_WIN: nxt_win = hwdata[6:0];
                ARS_OFS_FDATA: f_we = 1'b1;
                default: ;
            endcase
        end

        // Read data is sampled one cycle late so a prior write is visible
        if (state_ff == ARS_ST_RWAIT) begin
            unique case (addr_ff)
                ARS_OFS_CMD: nxt_hrdata = {8'h00, cmd_ff};
                ARS_OFS_ACC: nxt_hrdata = {24'h000000, acc_ff};
                ARS_OFS_FLAGS: nxt_hrdata = {29'h00000000, zero_ff, nb_ff, carry_ff};
                ARS_OFS_WIN: nxt_hrdata = {25'h0000000, win_ff};
                ARS_OFS_FDATA: nxt_hrdata = {24'h000000, win_data};
                ARS_OFS_COUNT: nxt_hrdata = {16'h0000, count_ff};
                default: nxt_hrdata = 32'h00000000;
            endcase
        end

        unique case (state_ff)
            ARS_ST_IDLE, ARS_ST_WRITE, ARS_ST_RDONE: begin
                if (take) begin
                    nxt_addr = {haddr[7:2], 2'b00};
                    nxt_state = hwrite ? ARS_ST_WRITE : ARS_ST_RWAIT;
                end
            end
            ARS_ST_RWAIT: nxt_state = ARS_ST_RDONE;
            default: nxt_state = ARS_ST_IDLE;
        endcase
    end

    // ============================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ARS_ST_IDLE;
            addr_ff <= ARS_OFS_CMD;
            acc_ff <= ARS_ACC_RST;
            carry_ff <= 1'b0;
            nb_ff <= 1'b0;
            zero_ff <= 1'b0;
            cmd_ff <= ARS_CMD_RST;
            win_ff <= ARS_WIN_RST;
            count_ff <= ARS_CNT_RST;
            hrdata_ff <= ARS_RDATA_RST;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            acc_ff <= nxt_acc;
            carry_ff <= nxt_carry;
            nb_ff <= nxt_nb;
            zero_ff <= nxt_zero;
            cmd_ff <= nxt_cmd;
            win_ff <= nxt_win;
            count_ff <= nxt_count;
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = (state_ff != ARS_ST_RWAIT);
    assign hresp = 1'b0;

    // ============================================================
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    rot_carry_a: assert property (exec && op_cur == ARS_OP_ROT |=> carry_ff == $past(fval[0]))
        else $error("rotate carry not taken from bit 0");
    rot_acc_a: assert property (exec && op_cur == ARS_OP_ROT && !dest_cur
        |=> acc_ff[7] == $past(carry_ff) && acc_ff[6:0] == $past(fval[7:1])
            && zero_ff == $past(zero_ff) && nb_ff == $past(nb_ff))
        else $error("rotate result to accumulator wrong");
    dest_file_a: assert property (exec && valid_op && file_op && dest_cur |=> acc_ff == $past(acc_ff))
        else $error("accumulator changed on file destination");
    rot_file_a: assert property ((exec && op_cur == ARS_OP_ROT && dest_cur)
        ##1 (fa_cur == $past(fa_cur))
        |-> fval[6:0] == $past(fval[7:1]) && fval[7] == $past(carry_ff))
        else $error("rotate result not written to file register");
    rot_flags_a: assert property (exec && op_cur == ARS_OP_ROT |=> $stable(zero_ff) && $stable(nb_ff))
        else $error("rotate changed a flag other than carry");
    subl_res_a: assert property (exec && op_cur == ARS_OP_SUBL
        |=> acc_ff == 8'($past(imm_cur) - $past(acc_ff)) && carry_ff == ($past(acc_ff) <= $past(imm_cur)))
        else $error("subtract from immediate result or carry wrong");
    subl_nb_a: assert property (exec && op_cur == ARS_OP_SUBL
        |=> nb_ff == ($past(acc_ff[3:0]) <= $past(imm_cur[3:0])))
        else $error("subtract from immediate nibble borrow wrong");
    subf_acc_a: assert property (exec && op_cur == ARS_OP_SUBF && !dest_cur
        |=> acc_ff == 8'($past(fval) - $past(acc_ff)) && carry_ff == ($past(acc_ff) <= $past(fval))
            && nb_ff == ($past(acc_ff[3:0]) <= $past(fval[3:0])))
        else $error("subtract from file result or flags wrong");
    xorl_res_a: assert property (exec && op_cur == ARS_OP_XORL
        |=> acc_ff == ($past(acc_ff) ^ $past(imm_cur)) && $stable(carry_ff) && $stable(nb_ff))
        else $error("xor immediate result or flags wrong");
    xorf_flags_a: assert property (exec && op_cur == ARS_OP_XORF
        |=> $stable(carry_ff) && $stable(nb_ff) && zero_ff == ($past(acc_ff) == $past(fval)))
        else $error("xor with file flags wrong");
    swap_res_a: assert property (exec && op_cur == ARS_OP_SWAP
        |=> $stable(carry_ff) && $stable(nb_ff) && $stable(zero_ff)
            && (dest_cur || acc_ff == {$past(fval[3:0]), $past(fval[7:4])}))
        else $error("nibble exchange result or flags wrong");
    zero_acc_a: assert property (exec && upd_zero && !to_file |=> zero_ff == (acc_ff == 8'h00))
        else $error("zero flag disagrees with accumulator");
    one_cycle_a: assert property (exec && valid_op |-> hreadyout ##1 count_ff == 16'($past(count_ff) + 16'h0001))
        else $error("instruction not completed in one cycle");

    // File results are read back through the operand port one cycle later; the
    // address guard skips a following command that moves that port elsewhere.
    subf_file_a: assert property ((exec && op_cur == ARS_OP_SUBF && dest_cur)
        ##1 (fa_cur == $past(fa_cur)) |-> fval == 8'($past(fval) - $past(acc_ff))
            && carry_ff == ($past(acc_ff) <= $past(fval)) && nb_ff == ($past(acc_ff[3:0]) <= $past(fval[3:0])))
        else $error("subtract from file to file register wrong");
    xorf_acc_a: assert property (exec && op_cur == ARS_OP_XORF && !dest_cur
        |=> acc_ff == ($past(acc_ff) ^ $past(fval)))
        else $error("xor with file result to accumulator wrong");
    xorf_file_a: assert property ((exec && op_cur == ARS_OP_XORF && dest_cur)
        ##1 (fa_cur == $past(fa_cur)) |-> fval == ($past(acc_ff) ^ $past(fval)))
        else $error("xor with file result to file register wrong");
    swap_file_a: assert property ((exec && op_cur == ARS_OP_SWAP && dest_cur)
        ##1 (fa_cur == $past(fa_cur)) |-> fval == {$past(fval[3:0]), $past(fval[7:4])} && acc_ff == $past(acc_ff))
        else $error("nibble exchange result not written to file register");
    zero_file_a: assert property ((exec && valid_op && upd_zero && to_file)
        ##1 (fa_cur == $past(fa_cur)) |-> zero_ff == (fval == 8'h00))
        else $error("zero flag disagrees with file result");
    noop_hold_a: assert property (exec && !valid_op
        |=> $stable(acc_ff) && $stable(count_ff) && $stable(carry_ff) && $stable(nb_ff) && $stable(zero_ff))
        else $error("reserved operation code changed state");

    // Reads always insert one wait state so hrdata can come from a flop
    read_wait_a: assert property (take && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait state");
    write_ready_a: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");

endmodule

// file: bench/ars_bus_master.sv
// AHB-Lite master model standing in for the software side of the slice.
// Assumes hready is the one slave's hreadyout and tasks are entered just after a rising edge.
`timescale 1ns/10ps

module ars_bus_master (
    // Clock and slave answer
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    // Looked at on the falling edge so the decision never races the rising edge's updates
    task automatic wait_ready(output logic [31:0] d);
        logic r;
        do begin
            @(negedge hclk);
            r = hready;
            d = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask

    task automatic start(input logic [7:0] a, input logic w);
        logic [31:0] d;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        start(a, 1'b1);
        hwdata <= v;
        wait_ready(d);
        // Released data lines show the inverse so a stale value is never taken for a good one
        hwdata <= ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        start(a, 1'b0);
        wait_ready(v);
    endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the rotate/subtract/xor/swap slice, driven over AHB-Lite.
// Assumes ars_top answers writes with no wait state and reads with one.
`timescale 1ns/10ps

module testbench
    import ars_pkg::*;
;
    typedef struct packed {
        logic [2:0] op;
        logic d;
        logic [6:0] fa;
        logic [7:0] a;
        logic [7:0] fv;
        logic [7:0] imm;
        logic [2:0] fl;
    } ars_row_t;

    localparam int N_ROWS = 15;
    localparam int LIMIT = 5000;
    localparam logic [7:0] RST_OFS [5] = '{ARS_OFS_CMD, ARS_OFS_ACC, ARS_OFS_FLAGS, ARS_OFS_WIN, ARS_OFS_COUNT};

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel;
    logic hwrite;
    logic hready_w;
    logic hresp;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [18:0] ex;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    // ============================================================
    // Cases: op, dest, file address, acc, file value, immediate, flags {zero, nb, carry}
    ars_row_t rows [N_ROWS] = '{
        '{3'h1, 1'h0, 7'h00, 8'h11, 8'hE6, 8'h00, 3'h0},
        '{3'h1, 1'h1, 7'h7F, 8'h00, 8'h81, 8'h00, 3'h1},
        '{3'h1, 1'h1, 7'h05, 8'h22, 8'h01, 8'h00, 3'h2},
        '{3'h2, 1'h0, 7'h01, 8'h05, 8'h44, 8'h05, 3'h0},
        '{3'h2, 1'h0, 7'h01, 8'h06, 8'h44, 8'h05, 3'h7},
        '{3'h2, 1'h1, 7'h02, 8'h1F, 8'h44, 8'h20, 3'h7},
        '{3'h3, 1'h0, 7'h03, 8'h10, 8'h08, 8'h00, 3'h0},
        '{3'h3, 1'h1, 7'h40, 8'h3C, 8'h3C, 8'h00, 3'h0},
        '{3'h4, 1'h0, 7'h04, 8'h5A, 8'h11, 8'h5A, 3'h3},
        '{3'h4, 1'h1, 7'h04, 8'hF0, 8'h11, 8'h0F, 3'h4},
        '{3'h5, 1'h0, 7'h09, 8'h33, 8'h0F, 8'h00, 3'h3},
        '{3'h5, 1'h1, 7'h7F, 8'h77, 8'h77, 8'h00, 3'h0},
        '{3'h6, 1'h0, 7'h02, 8'h00, 8'hA5, 8'h00, 3'h5},
        '{3'h6, 1'h1, 7'h00, 8'h99, 8'h3C, 8'h00, 3'h2},
        '{3'h2, 1'h1, 7'h06, 8'h80, 8'h55, 8'h00, 3'h0}
    };

    always #50 hclk = ~hclk;

    ars_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready_w), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready_w), .hresp(hresp));

    ars_bus_master i_mst (.hclk(hclk), .hready(hready_w), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ============================================================
    // Checking
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
            fail_count++;
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] v;
        i_mst.rd(a, v);
        chk(v, e, what);
    endtask

    // Returns {acc, file value, flags} expected after the operation
    function automatic logic [18:0] model(input ars_row_t r);
        logic [7:0] res;
        logic [2:0] f;
        logic to_f;
        f = r.fl;
        to_f = r.d;
        case (r.op)
            3'h1: begin
                res = {r.fl[0], r.fv[7:1]};
                f[0] = r.fv[0];
            end
            3'h2, 3'h3: begin
                res = (r.op == 3'h2) ? r.imm : r.fv;
                f[0] = (r.a <= res);
                f[1] = (r.a[3:0] <= res[3:0]);
                res = res - r.a;
            end
            3'h4: res = r.a ^ r.imm;
            3'h5: res = r.a ^ r.fv;
            default: res = {r.fv[3:0], r.fv[7:4]};
        endcase
        if (r.op inside {3'h2, 3'h3, 3'h4, 3'h5}) f[2] = (res == 8'h00);
        if (r.op inside {3'h2, 3'h4}) to_f = 1'b0;
        return to_f ? {r.a, res, f} : {res, r.fv, f};
    endfunction

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            $display("MISMATCH %0t run did not finish", $time);
            close_out();
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            ex = model(rows[i]);
            i_mst.wr(ARS_OFS_WIN, {25'h0, rows[i].fa});
            i_mst.wr(ARS_OFS_FDATA, {24'h0, rows[i].fv});
            i_mst.wr(ARS_OFS_ACC, {24'h0, rows[i].a});
            i_mst.wr(ARS_OFS_FLAGS, {29'h0, rows[i].fl});
            i_mst.wr(ARS_OFS_CMD, {8'h0, rows[i].imm, 5'h0, rows[i].fa, rows[i].d, rows[i].op});
            rd_chk(ARS_OFS_ACC, {24'h0, ex[18:11]}, "acc");
            rd_chk(ARS_OFS_FDATA, {24'h0, ex[10:3]}, "file");
            rd_chk(ARS_OFS_FLAGS, {29'h0, ex[2:0]}, "flags");
        end
        // Back-to-back rotates at the top file address: the carry must chain between them
        i_mst.wr(ARS_OFS_WIN, 32'h0000007F);
        i_mst.wr(ARS_OFS_FDATA, 32'h00000001);
        i_mst.wr(ARS_OFS_FLAGS, 32'h00000000);
        i_mst.wr(ARS_OFS_CMD, 32'h000007F9);
        i_mst.wr(ARS_OFS_CMD, 32'h000007F9);
        rd_chk(ARS_OFS_FDATA, 32'h00000080, "chained rotate");
        rd_chk(ARS_OFS_FLAGS, 32'h00000000, "chained carry");
        // Codes 0 and 7 execute nothing; count and unmapped space stay untouched
        i_mst.wr(ARS_OFS_ACC, 32'h0000005A);
        i_mst.wr(ARS_OFS_CMD, 32'h00A507FF);
        i_mst.wr(ARS_OFS_CMD, 32'h00A507F8);
        rd_chk(ARS_OFS_CMD, 32'h00A507F8, "cmd readback");
        rd_chk(ARS_OFS_ACC, 32'h0000005A, "acc after no-op");
        rd_chk(ARS_OFS_COUNT, N_ROWS + 2, "op count");
        i_mst.wr(ARS_OFS_COUNT, 32'h00001234);
        i_mst.wr(8'h18, 32'hFFFFFFFF);
        rd_chk(8'h18, 32'h00000000, "unmapped read");
        rd_chk(ARS_OFS_COUNT, N_ROWS + 2, "count read-only");
        // Second reset in mid-run
        hresetn <= 1'b0;
        repeat (2) @(negedge hclk);
        chk({30'h0, hready_w, hresp}, 32'h00000002, "bus in reset");
        chk(hrdata, 32'h00000000, "rdata in reset");
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (RST_OFS[k]) begin
            rd_chk(RST_OFS[k], 32'h00000000, "reset value");
        end
        close_out();
    end
endmodule
